// ==== i2c_arb_monitor.sv ====
// checker for the i2c arbitration block, watching only its top-level ports
// assumes the bench resolves the open-drain lines and speaks plain apb
module i2c_arb_monitor import i2c_arb_pkg::*; (
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // bus pins
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // system
   input wire logic port_irq,
   input wire logic wake_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access-phase decodes
   wire acc = psel && penable;
   wire st_rd = acc && !pwrite && paddr == OFF_STATUS;
   wire off_wr = acc && pwrite && paddr == OFF_CTRL && !pwdata[CTRL_EN];
   property p_rst_idle;
      $rose(presetn) |-> !scl_oe && !sda_oe && !port_irq;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("lines or irq active after reset");
   // a held-low clock must not be re-driven before it is seen high
   property p_stretch;
      !scl_oe && !scl_in |=> !scl_oe;
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock re-driven while held low");
   property p_high_min;
      $rose(scl_in) && !scl_oe |=> !scl_oe [*2];
   endproperty
   a_high_min: assert property (p_high_min) else $error("clock high time too short");
   property p_irq_read;
      st_rd && port_irq |-> prdata[ST_EVENT] || prdata[ST_BCOL];
   endproperty
   a_irq_read: assert property (p_irq_read) else $error("irq without a flag");
   // flags are sticky, so the irq only drops after a software write
   property p_irq_fall;
      $fell(port_irq) |-> $past(acc && pwrite);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped on its own");
   property p_wake;
      wake_req |-> port_irq;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without irq");
   property p_disable;
      off_wr |=> ##[0:2] !scl_oe && !sda_oe;
   endproperty
   a_disable: assert property (p_disable) else $error("lines held after disable");
   property p_od;
      !scl_out && !sda_out;
   endproperty
   a_od: assert property (p_od) else $error("pin driven high");
endmodule

bind i2c_master_bus_arbitration i2c_arb_monitor mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .port_irq(port_irq), .wake_req(wake_req)
);

// ==== i2c_arb_pkg.sv ====
// package for the i2c master arbitration block: register map, fields, resets
// assumes a 32-bit apb slave, byte addresses, one word per register
package i2c_arb_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SEQ = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_RATE = 8'h0C;
   localparam logic [7:0] OFF_BUF = 8'h10;
   // control register fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_IE = 1;
   localparam int CTRL_SLEEP = 2;
   // sequence control fields
   localparam int SEQ_START = 0;
   localparam int SEQ_RSTART = 1;
   localparam int SEQ_STOP = 2;
   localparam int SEQ_RECV = 3;
   localparam int SEQ_ACK = 4;
   localparam int SEQ_ACKDT = 5;
   // status fields
   localparam int ST_BF = 0;
   localparam int ST_START_SEEN = 3;
   localparam int ST_STOP_SEEN = 4;
   localparam int ST_EVENT = 8;
   localparam int ST_BCOL = 9;
   localparam int ST_ACKSTAT = 10;
   localparam int ST_WAKE = 11;
   // reset values
   localparam logic [6:0] RATE_RESET = 7'h00;
   localparam logic [7:0] BUF_RESET = 8'h00;
   // sequencer states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'b000_0001,
      ST_STA = 7'b000_0010,
      ST_RSTA = 7'b000_0100,
      ST_XFER = 7'b000_1000,
      ST_ACKS = 7'b001_0000,
      ST_STO = 7'b010_0000,
      ST_RECV = 7'b100_0000
   } seq_state_t;
endpackage

// ==== i2c_bus_partner.sv ====
// other masters and slaves on the shared open-drain bus
// assumes pull-ups on both lines; steps on a 1 ns time grid
module i2c_bus_partner (
   // design pull-down enables
   input wire logic scl_oe,
   input wire logic sda_oe,
   // resolved line levels
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hold_scl = 1'b0;
   logic hold_sda = 1'b0;
   // wired-and: whoever pulls low wins, a released line floats high
   assign scl = !(scl_oe || hold_scl);
   assign sda = !(sda_oe || hold_sda);
   // release data while the clock floats high, a stop seen by all masters
   task automatic stop_cond();
      #167;
      hold_sda = 1'b0;
      #160;
   endtask
   // a slave returns one byte, msb first, changing data only while the clock is low
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         hold_sda = !b[i];
         @(posedge scl);
         @(negedge scl);
      end
      hold_sda = 1'b0;
   endtask
   // another master pulls the clock low soon after it has risen, then lets go
   task automatic grab_clock();
      @(posedge scl);
      #140;
      hold_scl = 1'b1;
      #400;
      hold_scl = 1'b0;
   endtask
endmodule

// ==== i2c_master_bus_arbitration.sv ====
// i2c master sequencer with clock stretching and multi-master arbitration
// assumes open-drain pins resolved outside; apb master per amba; scl/sda async
// Functional notes
// - counter pauses until released clock reads high
// - clock high reloads counter from rate bits
// - sleep keeps receiving, wakes on byte if enabled
// - reset disables port and aborts transfer
// - start/stop seen cleared by reset, disable
// - stop detected while enabled raises port interrupt
// - released one read as zero is collision
// - loss detected in address, data, start, restart, ack
// - collision in transfer stops, clears full, releases
// - collision in sequences aborts, clears enables
// - after collision, stop sets port event flag
// - buffer write restarts from first bit
// - line low at start aborts with collision
// - start: data high loads; low clock collides
// - data low during first count asserts early
// - second start count ignores clock, then clock low
// - restart releases clock, low data collides
// - restart: early clock fall without data collides
// - restart ends driving data then clock low
// - stop: data low, release clock, check data
// - stop: clock low before data release collides
// - ack/stop completion idles, stop sets event
module i2c_master_bus_arbitration import i2c_arb_pkg::*; (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // i2c pins, open drain: oe high pulls low
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // system
   output logic port_irq,
   output logic wake_req
);
   // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
   logic [2:0] scl_sync, sda_sync;
   logic scl, sda;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl <= 1'b1;
         sda <= 1'b1;
      end else begin
         if (scl_sync[1] == scl_sync[2]) scl <= scl_sync[2];
         if (sda_sync[1] == sda_sync[2]) sda <= sda_sync[2];
      end
   end
   logic scl_q, sda_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   // bus condition detection from filtered levels
   wire start_det = scl && scl_q && sda_q && !sda;
   wire stop_det = scl && scl_q && !sda_q && sda;

   // apb decode
   wire wr = psel && penable && pwrite;
   wire rd_buf = psel && penable && !pwrite && (paddr == OFF_BUF);
   wire wr_ctrl = wr && (paddr == OFF_CTRL);
   wire wr_seq = wr && (paddr == OFF_SEQ);
   wire wr_stat = wr && (paddr == OFF_STATUS);
   wire wr_rate = wr && (paddr == OFF_RATE);
   wire wr_buf = wr && (paddr == OFF_BUF);
   wire mapped = (paddr == OFF_CTRL) || (paddr == OFF_SEQ) || (paddr == OFF_STATUS) ||
                 (paddr == OFF_RATE) || (paddr == OFF_BUF);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // registers
   logic enable, irq_en, sleeping;
   logic [6:0] rate_reload_register;
   logic [7:0] transfer_buffer, shifter;
   logic [5:0] sequence_control_reg;
   logic buffer_full_flag, port_event_flag, bus_collision_flag, ackstat;
   logic start_seen, stop_seen;
   seq_state_t state, next_state;
   logic [6:0] bit_rate_counter;
   logic brg_run;
   logic [1:0] phase;
   logic [3:0] bitcnt;
   logic scl_drv, sda_drv;

   // counter stops at zero while running and holds there until the sequencer reloads it
   wire brg_zero = brg_run && (bit_rate_counter == 7'h00);
   wire idle = (state == ST_IDLE);

   // collision detection per state and phase
   logic coll;
   always_comb begin
      coll = 1'b0;
      unique case (state)
         ST_IDLE: coll = 1'b0;
         ST_STA: coll = (phase == 2'd0 && (!sda || !scl)) ||
                        (phase == 2'd1 && sda && !scl);
         ST_RSTA: coll = (phase == 2'd1 && scl && !sda) ||
                         (phase == 2'd2 && sda && !scl);
         ST_XFER: coll = !sda_drv && scl && !sda && bitcnt < 4'd8;
         ST_ACKS: coll = !sda_drv && scl && !sda;
         ST_STO: coll = (phase == 2'd2 && !scl) ||
                        (phase == 2'd3 && brg_zero && !sda);
         ST_RECV: coll = 1'b0;
      endcase
   end

   wire abort = coll || !enable;
   // buffer writes are refused while a sequence runs or the buffer is full
   wire buf_ok = wr_buf && idle && !buffer_full_flag;
   wire byte_done = (state == ST_RECV) && brg_zero && phase == 2'd1 && bitcnt == 4'd7;
   wire ack_done = (state == ST_ACKS) && brg_zero && phase == 2'd1;
   wire stop_done = (state == ST_STO) && brg_zero && phase == 2'd3 && sda;
   wire xfer_done = (state == ST_XFER) && brg_zero && phase == 2'd1 && bitcnt == 4'd8;

   // sequencer, counter and line drivers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         phase <= 2'd0;
         bitcnt <= 4'h0;
         brg_run <= 1'b0;
         bit_rate_counter <= 7'h00;
         scl_drv <= 1'b0;
         sda_drv <= 1'b0;
         shifter <= 8'h00;
      end else if (abort) begin
         state <= ST_IDLE;
         brg_run <= 1'b0;
         scl_drv <= 1'b0;
         sda_drv <= 1'b0;
         phase <= 2'd0;
      end else begin
         if (brg_run && !brg_zero) bit_rate_counter <= bit_rate_counter - 7'h01;
         unique case (state)
            ST_IDLE: begin
               phase <= 2'd0;
               if (buf_ok) begin
                  state <= ST_XFER;
                  shifter <= pwdata[7:0];
                  bitcnt <= 4'h0;
                  sda_drv <= !pwdata[7];
                  bit_rate_counter <= rate_reload_register;
                  brg_run <= 1'b1;
               end else if (sequence_control_reg[SEQ_START]) begin
                  state <= ST_STA;
               end else if (sequence_control_reg[SEQ_RSTART]) begin
                  state <= ST_RSTA;
                  sda_drv <= 1'b0;
                  bit_rate_counter <= rate_reload_register;
                  brg_run <= 1'b1;
               end else if (sequence_control_reg[SEQ_STOP]) begin
                  state <= ST_STO;
                  sda_drv <= 1'b1;
               end else if (sequence_control_reg[SEQ_ACK]) begin
                  state <= ST_ACKS;
                  sda_drv <= !sequence_control_reg[SEQ_ACKDT];
                  scl_drv <= 1'b1;
                  bit_rate_counter <= rate_reload_register;
                  brg_run <= 1'b1;
               end else if (sequence_control_reg[SEQ_RECV]) begin
                  state <= ST_RECV;
                  sda_drv <= 1'b0;
                  bitcnt <= 4'h0;
                  bit_rate_counter <= rate_reload_register;
                  brg_run <= 1'b1;
               end
            end
            ST_STA: begin
               if (phase == 2'd0) begin
                  phase <= 2'd1;
                  bit_rate_counter <= rate_reload_register;
                  brg_run <= 1'b1;
               end else if (phase == 2'd1 && (!sda || brg_zero)) begin
                  sda_drv <= 1'b1;
                  phase <= 2'd2;
                  bit_rate_counter <= rate_reload_register;
               end else if (phase == 2'd2 && brg_zero) begin
                  scl_drv <= 1'b1;
                  brg_run <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_RSTA: begin
               if (phase == 2'd0 && brg_zero) begin
                  scl_drv <= 1'b0;
                  brg_run <= 1'b0;
                  phase <= 2'd1;
               end else if (phase == 2'd1 && scl) begin
                  bit_rate_counter <= rate_reload_register;
                  brg_run <= 1'b1;
                  phase <= 2'd2;
               end else if (phase == 2'd2 && (brg_zero || !sda)) begin
                  sda_drv <= 1'b1;
                  bit_rate_counter <= rate_reload_register;
                  phase <= 2'd3;
               end else if (phase == 2'd3 && brg_zero) begin
                  scl_drv <= 1'b1;
                  brg_run <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_XFER, ST_RECV, ST_ACKS: begin
               // phase 0: clock low count; phase 1: released, high count
               if (phase == 2'd0 && brg_zero) begin
                  scl_drv <= 1'b0;
                  brg_run <= 1'b0;
                  phase <= 2'd1;
               end else if (phase == 2'd1 && !brg_run && scl) begin
                  bit_rate_counter <= rate_reload_register;
                  brg_run <= 1'b1;
                  if (state == ST_RECV) shifter <= {shifter[6:0], sda};
                  if (state == ST_XFER && bitcnt == 4'd8) shifter <= {7'h00, sda};
               end else if (phase == 2'd1 && brg_zero) begin
                  scl_drv <= 1'b1;
                  phase <= 2'd0;
                  bit_rate_counter <= rate_reload_register;
                  bitcnt <= bitcnt + 4'h1;
                  if (xfer_done || byte_done || ack_done) begin
                     state <= ST_IDLE;
                     brg_run <= 1'b0;
                     if (state == ST_ACKS) sda_drv <= 1'b0;
                  end else if (state == ST_XFER) begin
                     shifter <= {shifter[6:0], 1'b0};
                     sda_drv <= (bitcnt < 4'd7) ? !shifter[6] : 1'b0;
                  end
               end
            end
            ST_STO: begin
               if (phase == 2'd0 && !sda) begin
                  scl_drv <= 1'b0;
                  phase <= 2'd1;
               end else if (phase == 2'd1 && scl) begin
                  bit_rate_counter <= rate_reload_register;
                  brg_run <= 1'b1;
                  phase <= 2'd2;
               end else if (phase == 2'd2 && brg_zero) begin
                  sda_drv <= 1'b0;
                  bit_rate_counter <= rate_reload_register;
                  phase <= 2'd3;
               end else if (stop_done) begin
                  brg_run <= 1'b0;
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // software-facing registers and flags; hardware set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable <= 1'b0;
         irq_en <= 1'b0;
         sleeping <= 1'b0;
         rate_reload_register <= RATE_RESET;
         transfer_buffer <= BUF_RESET;
         sequence_control_reg <= 6'h00;
         buffer_full_flag <= 1'b0;
         port_event_flag <= 1'b0;
         bus_collision_flag <= 1'b0;
         ackstat <= 1'b0;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            enable <= pwdata[CTRL_EN];
            irq_en <= pwdata[CTRL_IE];
            sleeping <= pwdata[CTRL_SLEEP];
         end else if (wake_req) begin
            sleeping <= 1'b0;
         end
         if (wr_rate) rate_reload_register <= pwdata[6:0];
         // enables accepted only when idle; cleared on start of use or abort
         if (abort) begin
            sequence_control_reg[4:0] <= 5'h00;
         end else if (wr_seq && idle) begin
            sequence_control_reg <= pwdata[5:0];
         end else if (idle && state != next_state) begin
            sequence_control_reg[4:0] <= 5'h00;
         end
         if (buf_ok) begin
            transfer_buffer <= pwdata[7:0];
            buffer_full_flag <= 1'b1;
         end else if (coll || xfer_done) begin
            buffer_full_flag <= 1'b0;
         end else if (byte_done) begin
            transfer_buffer <= shifter;
            buffer_full_flag <= 1'b1;
         end else if (rd_buf) begin
            buffer_full_flag <= 1'b0;
         end
         if (xfer_done) ackstat <= shifter[0];
         // events set the port flag: stop seen while enabled, own stop, byte received, transfer or ack done
         if (stop_det && enable || stop_done || byte_done || xfer_done || ack_done) begin
            port_event_flag <= 1'b1;
         end else if (wr_stat && pwdata[ST_EVENT]) begin
            port_event_flag <= 1'b0;
         end
         if (coll && enable) begin
            bus_collision_flag <= 1'b1;
         end else if (wr_stat && pwdata[ST_BCOL]) begin
            bus_collision_flag <= 1'b0;
         end
         if (!enable) begin
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
         end else if (start_det) begin
            start_seen <= 1'b1;
            stop_seen <= 1'b0;
         end else if (stop_det) begin
            stop_seen <= 1'b1;
            start_seen <= 1'b0;
         end
      end
   end

   // next_state only used to see that a sequence was launched from idle
   always_comb begin
      next_state = state;
      if (idle && (buf_ok || |sequence_control_reg[4:0])) next_state = ST_XFER;
   end

   // read mux
   wire [31:0] status_word = {21'h00000, ackstat, bus_collision_flag, port_event_flag, 3'h0,
                              stop_seen, start_seen, 2'h0, buffer_full_flag};
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         unique case (paddr)
            OFF_CTRL: prdata = {29'h0, sleeping, irq_en, enable};
            OFF_SEQ: prdata = {26'h0, sequence_control_reg};
            OFF_STATUS: prdata = status_word;
            OFF_RATE: prdata = {25'h0, rate_reload_register};
            OFF_BUF: prdata = {24'h0, transfer_buffer};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   // outputs: pins pulled low while drive is set; output levels tied low, not left to software
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_drv;
   assign sda_oe = sda_drv;
   assign port_irq = irq_en && (port_event_flag || bus_collision_flag);
   assign wake_req = sleeping && irq_en && port_event_flag;
endmodule

// ==== testbench.sv ====
// self-checking bench: apb master tasks, bus partner, one task per scenario
// assumes the checker binds itself to the design from its own file
module testbench import i2c_arb_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RATE = 4;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, rerr, scl_out, scl_oe, sda_out, sda_oe, port_irq, wake_req;
   wire logic scl, sda;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   i2c_master_bus_arbitration uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .port_irq(port_irq),
      .wake_req(wake_req));
   i2c_bus_partner bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   initial forever #20 pclk = ~pclk;
   // hang guard, far above the several hundred cycles the scenarios need
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (error_cnt == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chkb(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %b expected %b", $time, g, e);
      end
   endtask
   // one apb transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_lines(input logic s, input logic d);
      int n;
      n = 0;
      while ((scl_oe !== s || sda_oe !== d) && n < 3000) begin
         @(negedge pclk);
         n++;
      end
      chkb(scl_oe === s && sda_oe === d, 1'b1);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (port_irq !== 1'b1 && n < 3000) begin
         @(negedge pclk);
         n++;
      end
      chkb(port_irq, 1'b1);
   endtask
   task automatic wait_bit(input int i);
      int n;
      n = 0;
      rdata = 32'h0;
      while (rdata[i] !== 1'b1 && n < 300) begin
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end
      chkb(rdata[i], 1'b1);
   endtask
   task automatic t_reset();
      apb(1'b0, OFF_STATUS, 32'h0);
      chkb(|(rdata & 32'h0319), 1'b0);
      apb(1'b0, OFF_CTRL, 32'h0);
      chkb(|rdata[2:0], 1'b0);
      apb(1'b0, OFF_RATE, 32'h0);
      chkb(rdata[6:0] === RATE_RESET, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      chkb(rerr, 1'b1);
   endtask
   // own start: data is pulled before the clock, then the start enable reads clear and the event flag is cleared
   task automatic do_start();
      apb(1'b1, OFF_SEQ, 32'h1 << SEQ_START);
      wait_lines(1'b0, 1'b1);
      wait_lines(1'b1, 1'b1);
      apb(1'b0, OFF_SEQ, 32'h0);
      chkb(rdata[SEQ_START], 1'b0);
      apb(1'b1, OFF_STATUS, 32'h1 << ST_EVENT);
   endtask
   task automatic t_stretch();
      int n;
      bus.hold_scl = 1'b1;
      apb(1'b1, OFF_BUF, 32'h00);
      wait_lines(1'b0, 1'b1);
      repeat (40) begin
         @(negedge pclk);
         chkb(scl_oe, 1'b0);
      end
      bus.hold_scl = 1'b0;
      n = 0;
      while (scl_oe !== 1'b1 && n < 500) begin
         @(negedge pclk);
         n++;
      end
      chkb(n >= RATE + 1, 1'b1);
      wait_irq();
      apb(1'b0, OFF_STATUS, 32'h0);
      chkb(rdata[ST_BF], 1'b0);
      apb(1'b1, OFF_STATUS, 32'h1 << ST_EVENT);
   endtask
   task automatic t_stop();
      apb(1'b1, OFF_SEQ, 32'h1 << SEQ_STOP);
      wait_lines(1'b0, 1'b0);
      wait_bit(ST_STOP_SEEN);
      wait_irq();
      apb(1'b0, OFF_SEQ, 32'h0);
      chkb(rdata[SEQ_STOP], 1'b0);
      apb(1'b1, OFF_STATUS, 32'h1 << ST_EVENT);
   endtask
   // repeated start from a held clock: data up, clock up, data down, clock down
   task automatic t_restart();
      apb(1'b1, OFF_SEQ, 32'h1 << SEQ_RSTART);
      wait_lines(1'b0, 1'b0);
      wait_lines(1'b0, 1'b1);
      wait_lines(1'b1, 1'b1);
      apb(1'b0, OFF_STATUS, 32'h0);
      chkb(rdata[ST_BCOL], 1'b0);
   endtask
   // a slave returns a byte while the host sleeps, then the byte is acknowledged
   task automatic t_recv();
      apb(1'b1, OFF_CTRL, 32'h7);
      apb(1'b1, OFF_SEQ, 32'h1 << SEQ_RECV);
      bus.send_byte(8'hA5);
      @(negedge pclk);
      wait_irq();
      chkb(wake_req, 1'b1);
      apb(1'b0, OFF_BUF, 32'h0);
      chkb(rdata[7:0] === 8'hA5, 1'b1);
      apb(1'b1, OFF_SEQ, 32'h1 << SEQ_ACK);
      wait_lines(1'b0, 1'b1);
      wait_lines(1'b1, 1'b0);
      apb(1'b1, OFF_STATUS, 32'h1 << ST_EVENT);
   endtask
   // another master pulls the clock low while our stop still holds data low
   task automatic t_stop_coll();
      do_start();
      apb(1'b1, OFF_SEQ, 32'h1 << SEQ_STOP);
      bus.grab_clock();
      wait_bit(ST_BCOL);
      chkb(scl_oe || sda_oe, 1'b0);
      apb(1'b1, OFF_STATUS, 32'h300);
   endtask
   // another master keeps data low while a one is sent
   task automatic t_collide();
      do_start();
      bus.hold_sda = 1'b1;
      apb(1'b1, OFF_BUF, 32'h80);
      wait_irq();
      apb(1'b0, OFF_STATUS, 32'h0);
      chkb(rdata[ST_BCOL], 1'b1);
      chkb(rdata[ST_BF], 1'b0);
      wait_lines(1'b0, 1'b0);
      bus.stop_cond();
      wait_bit(ST_STOP_SEEN);
      chkb(rdata[ST_EVENT], 1'b1);
      chkb(rdata[ST_BCOL], 1'b1);
      apb(1'b1, OFF_STATUS, 32'h300);
      @(negedge pclk);
      chkb(port_irq, 1'b0);
   endtask
   task automatic t_busy();
      bus.hold_sda = 1'b1;
      repeat (8) @(posedge pclk);
      apb(1'b1, OFF_SEQ, 32'h1 << SEQ_START);
      wait_bit(ST_BCOL);
      apb(1'b0, OFF_SEQ, 32'h0);
      chkb(rdata[SEQ_START], 1'b0);
      chkb(scl_oe || sda_oe, 1'b0);
      bus.stop_cond();
      apb(1'b1, OFF_STATUS, 32'h300);
   endtask
   task automatic t_disable();
      do_start();
      apb(1'b1, OFF_CTRL, 32'h0);
      wait_lines(1'b0, 1'b0);
      apb(1'b0, OFF_STATUS, 32'h0);
      chkb(rdata[ST_START_SEEN] || rdata[ST_STOP_SEEN], 1'b0);
   endtask
   // a foreign start and stop while asleep raises the irq and the wake request
   task automatic t_sleep();
      apb(1'b1, OFF_CTRL, 32'h7);
      bus.hold_sda = 1'b1;
      repeat (8) @(posedge pclk);
      bus.stop_cond();
      wait_irq();
      chkb(wake_req, 1'b1);
      apb(1'b1, OFF_STATUS, 32'h300);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      apb(1'b1, OFF_RATE, RATE);
      apb(1'b1, OFF_CTRL, 32'h3);
      do_start();
      t_stretch();
      t_restart();
      t_recv();
      t_stop();
      t_stop_coll();
      t_collide();
      t_busy();
      t_disable();
      t_sleep();
      complete_run();
   end
endmodule
